// File: rtl/ust_params.svh
/*
  Offsets, field positions, values and timing counts of the USART
  control slice. Assumes inclusion by bare name from the rtl folder.
*/
`ifndef UST_PARAMS_SVH
`define UST_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define UST_OFF_USART_CONTROL_A   8'h00
`define UST_OFF_USART_CONTROL_B   8'h04
`define UST_OFF_MASK    8'h08
`define UST_OFF_STAT    8'h0C
`define UST_OFF_SYNC    8'h10
`define UST_OFF_DATA    8'h14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define UST_USART_CONTROL_A_ENABLE 1
`define UST_USART_CONTROL_A_FRAME_FORMAT_FIELD   27:24
`define UST_USART_CONTROL_A_FRAME_FORMAT_FIELD_LSB 24
`define UST_USART_CONTROL_B_RXEN   17
`define UST_USART_CONTROL_B_TRANSMIT_ENABLE_BIT   16
`define UST_USART_CONTROL_B_PARITY_ODD_SELECT  13
`define UST_USART_CONTROL_B_ENC    10
`define UST_USART_CONTROL_B_FRAME_START_WAKE_ENABLE   9
`define UST_IRQ_TXC      0
`define UST_IRQ_RXC      1
`define UST_IRQ_RXS      2
`define UST_IRQ_PARITY_ERROR_FLAG     3
`define UST_SYNC_ENABLE  1
`define UST_SYNC_USART_CONTROL_B   2

// ---------------------------------------------------------------
// Values and timing counts
// ---------------------------------------------------------------
`define UST_FRAME_FORMAT_FIELD_PARITY  4'h1
`define UST_BIT_LAST     4'hF
`define UST_BIT_MID      4'h7
`define UST_IRDA_PULSE   4'h3
`define UST_SYNC_LAST    2'h2
`define UST_DATA_LAST    3'h7
`define UST_ZERO32       32'h0000_0000

`endif

// File: rtl/ust_pkg.sv
/*
  Types of the USART control slice: enable sequencing states, serial
  shifter states, state records and the parity function.
  Assumes ust_params.svh is reachable by bare name.
*/
package ust_pkg;

  // Enable sequencing of transmitter and receiver
  typedef enum logic [1:0] {EN_OFF, EN_START, EN_ON, EN_DRAIN} ust_en_t;

  // Serial frame position
  typedef enum logic [2:0] {SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP} ust_ser_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        enable;
    logic [3:0]  frame_format_field;
    logic        transmit_enable_bit_req;
    logic        transmit_enable_bit_from_en;
    logic        rxen_req;
    logic        parity_odd_select;
    logic        line_encoding_select;
    logic        frame_start_wake_enable;
    logic [3:0]  mask;
    logic [3:0]  stat;
    ust_en_t     tx_st;
    logic [1:0]  tx_sync;
    ust_en_t     rx_st;
    logic [1:0]  rx_sync;
    logic [7:0]  tx_data;
    logic        tx_full;
    ust_ser_t    tx_ser;
    logic [3:0]  tx_cnt;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        tx_par;
    logic        txd;
    ust_ser_t    rx_ser;
    logic [3:0]  rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_par;
    logic [7:0]  rx_data;
  } ust_state_t;

  typedef struct packed {
    logic       txd_pin;
    logic       rx_level;
    logic [3:0] cnt;
  } ust_irda_t;

  typedef struct packed {
    logic prev;
    logic start;
    logic wake;
  } ust_sof_t;

  // Parity over data, odd selects odd parity
  function automatic logic ust_parity(input logic [7:0] d, input logic odd);
    ust_parity = (^d) ^ odd;
  endfunction

endpackage

// File: rtl/ust_irda.sv
/*
  Line coder: plain pass-through or IrDA pulse encoding and decoding.
  Assumes the bit phase counter of the transmitter as timing reference.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ust_params.svh"

module ust_irda
  import ust_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Control
  input  wire logic       line_encoding_select,
  input  wire logic       txd,
  input  wire logic [3:0] tx_phase,
  // Line
  input  wire logic       rxd_pin,
  output logic            txd_pin,
  output logic            rx_level
);

  ust_irda_t s;
  ust_irda_t next_s;

  // Zero bits become short high pulses; a pulse is stretched to a full bit
  always_comb
  begin
    next_s = s;
    if (line_encoding_select)
    begin
      // Internal bit lags the phase count by one clock
      next_s.txd_pin = ~txd & (4'(tx_phase - 4'h1) < `UST_IRDA_PULSE);
      if (rxd_pin)
        next_s.cnt = `UST_BIT_LAST;
      else if (s.cnt != 4'h0)
        next_s.cnt = s.cnt - 4'h1;
      next_s.rx_level = ~rxd_pin & (s.cnt == 4'h0);
    end
    else
    begin
      next_s.txd_pin  = txd;
      next_s.cnt      = 4'h0;
      next_s.rx_level = rxd_pin;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      s <= '{txd_pin: 1'b1, rx_level: 1'b1, cnt: 4'h0};
    else
      s <= next_s;
  end

  assign txd_pin  = s.txd_pin;
  assign rx_level = s.rx_level;

  AST_ENC_PLAIN: assert property (@(posedge clk_sys) disable iff (srst)
    !line_encoding_select |=> (txd_pin == $past(txd))) else $error("plain mode altered txd");

endmodule // ust_irda

`default_nettype wire

// File: rtl/ust_sof.sv
/*
  Start-of-frame detector and wake request.
  Assumes a decoded receive level that idles high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ust_params.svh"

module ust_sof
  import ust_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Control
  input  wire logic en,
  input  wire logic rxs_en,
  input  wire logic rxc_en,
  input  wire logic rx_level,
  input  wire logic rxc_event,
  // Outputs
  output logic      start,
  output logic      wake
);

  ust_sof_t s;
  ust_sof_t next_s;

  // Falling edge is a start bit; start and receive-complete wakes each need their own enable
  always_comb
  begin
    next_s       = s;
    next_s.prev  = rx_level;
    next_s.start = en & s.prev & ~rx_level;
    next_s.wake  = en & ((next_s.start & rxs_en) | (rxc_event & rxc_en));
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      s <= '{prev: 1'b1, start: 1'b0, wake: 1'b0};
    else
      s <= next_s;
  end

  assign start = s.start;
  assign wake  = s.wake;

  AST_SOF_OFF: assert property (@(posedge clk_sys) disable iff (srst)
    !en |=> !wake) else $error("wake while detector off");

endmodule // ust_sof

`default_nettype wire

// File: rtl/ust_ctrl.sv
/*
  USART control slice: Avalon-MM register file, transmitter and receiver
  enable sequencing, parity, IrDA selection and start-of-frame wake.
  Assumes a synchronous remote peer at a fixed bit period of 16 clocks.
*/
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
// Summary of operation
// - Clearing transmit enable stops only after queued and active frames finish.
// - Transmit enable written while disabled sets at once.
// - On block enable, pending transmit enable reads zero with sync busy.
// - Writing transmit enable while enabled raises sync busy, reads one.
// - Transmit enable stays writable while the block is enabled.
// - Transmit enable reads its written value, except zero while starting after block enable.
// - Receive enable reads its written value while the block is disabled; while enabled, zero when off or starting.
// - Parity used only when the frame format field equals one.
// - Parity mode zero is even, one is odd.
// - Transmitter appends its own parity bit after the data.
// - Receiver flags parity error on data plus parity mismatch.
// - Encoding select zero plain, one IrDA pulse coding.
// - Parity, encoding and wake bits act without sync handshake.
// - Frame-start wake bit governs start detection wake.
// - Wake enabled with receive-complete enable wakes from every sleep mode.
`timescale 1ns/1ps
`default_nettype none
`include "ust_params.svh"

module ust_ctrl
  import ust_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Serial line
  input  wire logic        rxd_pin,
  output logic             txd_pin,
  // System
  output logic             irq,
  output logic             wake
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  ust_state_t  s;
  ust_state_t  next_s;
  logic        rx_level;
  logic        sof_start;
  logic        rxc_event;
  logic        parity_error_flag_event;
  logic        txc_event;
  logic        req;
  logic        acc_wr;
  logic        acc_rd;
  logic        transmit_enable_bit_rd;
  logic        rxen_rd;
  logic        sync_usart_control_b;
  logic [31:0] wdata;
  logic [31:0] usart_control_b_rd;

  // Merge a write under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // One wait cycle so read data can come from a register
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~s.ack;
  assign acc_wr          = avs_write & s.ack;
  assign acc_rd          = avs_read & s.ack;
  assign wdata           = merge(`UST_ZERO32, avs_writedata, avs_byteenable);
  assign avs_readdata    = s.rdata;

  // Readback views
  // transmit enable view
  assign transmit_enable_bit_rd    = s.transmit_enable_bit_req & ~(s.tx_st == EN_START & s.transmit_enable_bit_from_en);
  assign rxen_rd    = s.rxen_req & ((s.rx_st == EN_ON) | ~s.enable);
  assign sync_usart_control_b = (s.tx_st == EN_START) | (s.rx_st == EN_START);
  assign usart_control_b_rd   = (32'(rxen_rd) << `UST_USART_CONTROL_B_RXEN) | (32'(transmit_enable_bit_rd) << `UST_USART_CONTROL_B_TRANSMIT_ENABLE_BIT)
                    | (32'(s.parity_odd_select) << `UST_USART_CONTROL_B_PARITY_ODD_SELECT) | (32'(s.line_encoding_select) << `UST_USART_CONTROL_B_ENC)
                    | (32'(s.frame_start_wake_enable) << `UST_USART_CONTROL_B_FRAME_START_WAKE_ENABLE);

  // Frame events
  assign txc_event  = (s.tx_ser == SER_STOP) & (s.tx_cnt == `UST_BIT_LAST);
  assign rxc_event  = (s.rx_ser == SER_STOP) & (s.rx_cnt == `UST_BIT_MID);
  assign parity_error_flag_event = rxc_event & (s.frame_format_field == `UST_FRAME_FORMAT_FIELD_PARITY)
                    & (((^s.rx_sh) ^ s.rx_par) != s.parity_odd_select);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s     = s;
    next_s.ack = req & ~s.ack;
    next_s.txd = 1'b1;

    // Read data latched in the wait cycle
    if (req & ~s.ack)
    begin
      unique case (avs_address)
        `UST_OFF_USART_CONTROL_A: next_s.rdata = (32'(s.enable) << `UST_USART_CONTROL_A_ENABLE)
                                     | (32'(s.frame_format_field) << `UST_USART_CONTROL_A_FRAME_FORMAT_FIELD_LSB);
        `UST_OFF_USART_CONTROL_B: next_s.rdata = usart_control_b_rd;
        `UST_OFF_MASK:  next_s.rdata = 32'(s.mask);
        `UST_OFF_STAT:  next_s.rdata = 32'(s.stat);
        `UST_OFF_SYNC:  next_s.rdata = 32'(sync_usart_control_b) << `UST_SYNC_USART_CONTROL_B;
        `UST_OFF_DATA:  next_s.rdata = 32'(s.rx_data);
        default:        next_s.rdata = `UST_ZERO32;
      endcase
    end

    // Register writes
    if (acc_wr)
    begin
      unique case (avs_address)
        `UST_OFF_USART_CONTROL_A:
        begin
          next_s.enable = wdata[`UST_USART_CONTROL_A_ENABLE];
          // Frame format is enable-protected
          if (!s.enable)
            next_s.frame_format_field = wdata[`UST_USART_CONTROL_A_FRAME_FORMAT_FIELD];
        end
        `UST_OFF_USART_CONTROL_B:
        begin
          // enable bits writable at any time
          next_s.transmit_enable_bit_req = wdata[`UST_USART_CONTROL_B_TRANSMIT_ENABLE_BIT];
          next_s.rxen_req = wdata[`UST_USART_CONTROL_B_RXEN];
          if (wdata[`UST_USART_CONTROL_B_TRANSMIT_ENABLE_BIT] & ~s.enable)
            next_s.transmit_enable_bit_from_en = 1'b1;
          // mode bits act directly, no handshake
          if (!s.enable)
          begin
            next_s.parity_odd_select = wdata[`UST_USART_CONTROL_B_PARITY_ODD_SELECT];
            next_s.line_encoding_select   = wdata[`UST_USART_CONTROL_B_ENC];
            next_s.frame_start_wake_enable  = wdata[`UST_USART_CONTROL_B_FRAME_START_WAKE_ENABLE];
          end
        end
        `UST_OFF_MASK: next_s.mask = wdata[3:0];
        `UST_OFF_DATA:
        begin
          // Writes to a full holding register are dropped
          if (!s.tx_full)
          begin
            next_s.tx_data = wdata[7:0];
            next_s.tx_full = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Status: read clears, a new event wins
    if (acc_rd && avs_address == `UST_OFF_STAT)
      next_s.stat = 4'h0;
    next_s.stat[`UST_IRQ_TXC]  = next_s.stat[`UST_IRQ_TXC] | txc_event;
    next_s.stat[`UST_IRQ_RXC]  = next_s.stat[`UST_IRQ_RXC] | rxc_event;
    next_s.stat[`UST_IRQ_RXS]  = next_s.stat[`UST_IRQ_RXS] | sof_start;
    next_s.stat[`UST_IRQ_PARITY_ERROR_FLAG] = next_s.stat[`UST_IRQ_PARITY_ERROR_FLAG] | parity_error_flag_event;

    // Transmitter enable sequencing
    unique case (s.tx_st)
      EN_OFF:
        if (s.enable & s.transmit_enable_bit_req)
        begin
          next_s.tx_st   = EN_START;
          next_s.tx_sync = 2'h0;
        end
      EN_START:
      begin
        next_s.tx_sync = s.tx_sync + 2'h1;
        if (s.tx_sync == `UST_SYNC_LAST)
        begin
          next_s.tx_st        = EN_ON;
          next_s.transmit_enable_bit_from_en = 1'b0;
        end
      end
      EN_ON:
        if (~s.transmit_enable_bit_req | ~s.enable)
          next_s.tx_st = EN_DRAIN;
      EN_DRAIN:
        // finish active and queued frames first
        if (s.tx_ser == SER_IDLE && !s.tx_full)
          next_s.tx_st = EN_OFF;
      default: next_s.tx_st = EN_OFF;
    endcase

    // Receiver enable sequencing
    unique case (s.rx_st)
      EN_OFF:
        if (s.enable & s.rxen_req)
        begin
          next_s.rx_st   = EN_START;
          next_s.rx_sync = 2'h0;
        end
      EN_START:
      begin
        next_s.rx_sync = s.rx_sync + 2'h1;
        if (s.rx_sync == `UST_SYNC_LAST)
          next_s.rx_st = EN_ON;
      end
      default:
        if (~s.rxen_req | ~s.enable)
          next_s.rx_st = EN_OFF;
    endcase

    // Transmit shifter
    next_s.tx_cnt = s.tx_cnt + 4'h1;
    unique case (s.tx_ser)
      SER_IDLE:
      begin
        next_s.tx_cnt = 4'h0;
        if (s.tx_full && (s.tx_st == EN_ON || s.tx_st == EN_DRAIN))
        begin
          next_s.tx_ser  = SER_START;
          next_s.tx_sh   = s.tx_data;
          // parity from the frame's own data
          next_s.tx_par  = ust_parity(s.tx_data, s.parity_odd_select);
          next_s.tx_full = 1'b0;
        end
      end
      SER_START:
      begin
        next_s.txd = 1'b0;
        if (s.tx_cnt == `UST_BIT_LAST)
        begin
          next_s.tx_ser = SER_DATA;
          next_s.tx_bit = 3'h0;
        end
      end
      SER_DATA:
      begin
        next_s.txd = s.tx_sh[0];
        if (s.tx_cnt == `UST_BIT_LAST)
        begin
          next_s.tx_sh  = {1'b0, s.tx_sh[7:1]};
          next_s.tx_bit = s.tx_bit + 3'h1;
          // parity bit only with parity format
          if (s.tx_bit == `UST_DATA_LAST)
            next_s.tx_ser = (s.frame_format_field == `UST_FRAME_FORMAT_FIELD_PARITY) ? SER_PAR : SER_STOP;
        end
      end
      SER_PAR:
      begin
        next_s.txd = s.tx_par;
        if (s.tx_cnt == `UST_BIT_LAST)
          next_s.tx_ser = SER_STOP;
      end
      SER_STOP:
        if (s.tx_cnt == `UST_BIT_LAST)
          next_s.tx_ser = SER_IDLE;
      default: next_s.tx_ser = SER_IDLE;
    endcase

    // Receive shifter, sampled at mid bit
    next_s.rx_cnt = s.rx_cnt + 4'h1;
    unique case (s.rx_ser)
      SER_IDLE:
      begin
        next_s.rx_cnt = 4'h0;
        if (s.rx_st == EN_ON && !rx_level)
          next_s.rx_ser = SER_START;
      end
      SER_START:
      begin
        // A start bit gone by mid bit was a glitch
        if (s.rx_cnt == `UST_BIT_MID && rx_level)
          next_s.rx_ser = SER_IDLE;
        if (s.rx_cnt == `UST_BIT_LAST)
        begin
          next_s.rx_ser = SER_DATA;
          next_s.rx_bit = 3'h0;
        end
      end
      SER_DATA:
      begin
        if (s.rx_cnt == `UST_BIT_MID)
          next_s.rx_sh = {rx_level, s.rx_sh[7:1]};
        if (s.rx_cnt == `UST_BIT_LAST)
        begin
          next_s.rx_bit = s.rx_bit + 3'h1;
          if (s.rx_bit == `UST_DATA_LAST)
            next_s.rx_ser = (s.frame_format_field == `UST_FRAME_FORMAT_FIELD_PARITY) ? SER_PAR : SER_STOP;
        end
      end
      SER_PAR:
      begin
        if (s.rx_cnt == `UST_BIT_MID)
          next_s.rx_par = rx_level;
        if (s.rx_cnt == `UST_BIT_LAST)
          next_s.rx_ser = SER_STOP;
      end
      SER_STOP:
        // Back to idle at mid stop so the next start is not missed
        if (s.rx_cnt == `UST_BIT_MID)
        begin
          next_s.rx_ser  = SER_IDLE;
          next_s.rx_data = s.rx_sh;
        end
      default: next_s.rx_ser = SER_IDLE;
    endcase
    if (s.rx_st != EN_ON)
      next_s.rx_ser = SER_IDLE;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s         <= '0;
      s.tx_st   <= EN_OFF;
      s.rx_st   <= EN_OFF;
      s.tx_ser  <= SER_IDLE;
      s.rx_ser  <= SER_IDLE;
      s.txd     <= 1'b1;
    end
    else
      s <= next_s;
  end

  // Interrupt level
  assign irq = |(s.stat & s.mask);

  // ---------------------------------------------------------------
  // Line coder and start detector
  // ---------------------------------------------------------------
  // coding chosen by encoding select
  ust_irda u_irda (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .line_encoding_select      (s.line_encoding_select),
    .txd      (s.txd),
    .tx_phase (s.tx_cnt),
    .rxd_pin  (rxd_pin),
    .txd_pin  (txd_pin),
    .rx_level (rx_level)
  );

  ust_sof u_sof (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .en        (s.frame_start_wake_enable & (s.rx_st == EN_ON)),
    .rxs_en    (s.mask[`UST_IRQ_RXS]),
    .rxc_en    (s.mask[`UST_IRQ_RXC]),
    .rx_level  (rx_level),
    .rxc_event (rxc_event),
    .start     (sof_start),
    .wake      (wake)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_TRANSMIT_ENABLE_BIT_IMMEDIATE: assert property (@(posedge clk_sys) disable iff (srst)
    acc_wr && avs_address == `UST_OFF_USART_CONTROL_B && wdata[`UST_USART_CONTROL_B_TRANSMIT_ENABLE_BIT] && !s.enable
    |=> transmit_enable_bit_rd) else $error("transmit enable not set at once");

  AST_PENDING_READ: assert property (@(posedge clk_sys) disable iff (srst)
    (s.tx_st == EN_START && s.transmit_enable_bit_from_en) |-> (!transmit_enable_bit_rd && sync_usart_control_b))
    else $error("pending transmit enable misread");

  AST_SYNC_ON_WRITE: assert property (@(posedge clk_sys) disable iff (srst)
    acc_wr && avs_address == `UST_OFF_USART_CONTROL_B && wdata[`UST_USART_CONTROL_B_TRANSMIT_ENABLE_BIT] && s.enable
    && s.tx_st == EN_OFF |=> ##1 (sync_usart_control_b && transmit_enable_bit_rd)) else $error("sync busy missing");

  AST_DRAIN: assert property (@(posedge clk_sys) disable iff (srst)
    (s.tx_st == EN_DRAIN && s.tx_ser != SER_IDLE) |=> s.tx_st != EN_OFF)
    else $error("transmitter stopped mid frame");

  AST_RXEN_START: assert property (@(posedge clk_sys) disable iff (srst)
    s.rx_st == EN_START |-> !rxen_rd) else $error("receive enable read one while starting");

  AST_PARITY_FRAME_FORMAT_FIELD: assert property (@(posedge clk_sys) disable iff (srst)
    s.tx_ser == SER_PAR |-> s.frame_format_field == `UST_FRAME_FORMAT_FIELD_PARITY) else $error("parity without parity frame_format_field");

  AST_PARITY_BIT: assert property (@(posedge clk_sys) disable iff (srst)
    (s.tx_ser == SER_DATA && s.tx_bit == `UST_DATA_LAST && s.tx_cnt == `UST_BIT_LAST
     && s.frame_format_field == `UST_FRAME_FORMAT_FIELD_PARITY) |=> ##1 (s.txd == (s.tx_par ^ 1'b0)) [*8])
    else $error("parity bit not on line");

  AST_PARITY_ERROR_FLAG_SET: assert property (@(posedge clk_sys) disable iff (srst)
    parity_error_flag_event |=> s.stat[`UST_IRQ_PARITY_ERROR_FLAG]) else $error("parity error not flagged");

  AST_MODE_DIRECT: assert property (@(posedge clk_sys) disable iff (srst)
    acc_wr && avs_address == `UST_OFF_USART_CONTROL_B && !s.enable
    |=> s.parity_odd_select == $past(wdata[`UST_USART_CONTROL_B_PARITY_ODD_SELECT])) else $error("parity mode not direct");

  COV_TX_FRAME: cover property (@(posedge clk_sys) disable iff (srst) txc_event);
  COV_PARITY_ERROR_FLAG: cover property (@(posedge clk_sys) disable iff (srst) parity_error_flag_event);
  COV_WAKE: cover property (@(posedge clk_sys) disable iff (srst) wake);

endmodule // ust_ctrl

`default_nettype wire

// File: tb/ust_peer.sv
/*
  Remote serial peer: frame sender on the receive line, mid-bit sampler
  of the transmit line. Assumes plain coding and 16 clocks per bit.
*/
`timescale 1ns/1ps
`default_nettype none

module ust_peer (
  // Clock
  input  wire logic       clk_sys,
  // Line
  input  wire logic       txd_pin,
  output logic            rxd_pin,
  // Capture: data bits and the bit after them
  output logic [8:0]      got,
  output int              got_n
);
  logic [8:0] sh;

  initial
  begin
    rxd_pin = 1'b1;
    got     = 9'h000;
    got_n   = 0;
  end

  // One frame; parity slot skipped when absent, line idles high after
  task automatic send(input logic [7:0] d, input logic par, input logic has_par);
    logic [10:0] f;
    f = {1'b1, par, d, 1'b0};
    for (int i = 0; i < 11; i++)
      if (i != 9 || has_par)
      begin
        rxd_pin <= f[i];
        repeat (16) @(posedge clk_sys);
      end
  endtask

  // Sampler: mid start, then nine bit centres
  initial forever
  begin
    @(negedge txd_pin);
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 9; i++)
    begin
      repeat (16) @(posedge clk_sys);
      sh[i] = txd_pin;
    end
    got   <= sh;
    got_n <= got_n + 1;
  end
endmodule // ust_peer

`default_nettype wire

// File: tb/ust_ctrl_bench.sv
/*
  Self-checking bench of the USART control slice: register sequencing,
  transmit parity and drain, receive parity error with irq, wake, IrDA.
  Assumes ust_peer as the remote end of the serial line.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ust_params.svh"

module ust_ctrl_bench;
  localparam logic [7:0]  CA = `UST_OFF_USART_CONTROL_A, CB = `UST_OFF_USART_CONTROL_B, MK = `UST_OFF_MASK;
  localparam logic [7:0]  ST = `UST_OFF_STAT, SY = `UST_OFF_SYNC, DT = `UST_OFF_DATA;
  localparam logic [31:0] TX = 32'h0001_0000, RX = 32'h0002_0000, PM = 32'h0000_2000;
  localparam logic [31:0] EN = 32'h0000_0400, SF = 32'h0000_0200;
  logic        clk_sys, srst, rd, wr, wrq, rxd_pin, txd_pin, irq, wake;
  logic [7:0]  adr;
  logic [31:0] wd, rdat, q;
  logic [8:0]  got;
  int          got_n, wake_n, failures, cmp_count, n;

  ust_ctrl u_ust_ctrl (.clk_sys(clk_sys), .srst(srst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
    .avs_waitrequest(wrq), .rxd_pin(rxd_pin), .txd_pin(txd_pin), .irq(irq), .wake(wake));
  ust_peer u_ust_peer (.clk_sys(clk_sys), .txd_pin(txd_pin), .rxd_pin(rxd_pin),
    .got(got), .got_n(got_n));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Wake pulse counter
  always @(posedge clk_sys)
    if (wake === 1'b1)
      wake_n <= wake_n + 1;

  // Avalon-MM transfer; an edge always passes between two requests
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do @(posedge clk_sys); while (wrq !== 1'b0 && ++k < 50);
    if (k == 50)
      failures++;
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic cmpv(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0);
    cmpv(s, e, q);
  endtask

  // Protected bits only change while the block is off
  task automatic cfg(input logic [3:0] frm, input logic [31:0] cb);
    bus(1'b1, CA, 32'h0);
    bus(1'b1, CB, cb);
    bus(1'b1, CA, {4'h0, frm, 24'h00_0002});
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic wait_frame(input int m);
    n = 0;
    while (got_n < m && n < 500)
    begin
      @(posedge clk_sys);
      n++;
    end
    cmpv("frame count", m, got_n);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog, far beyond the few thousand cycles of the run
  initial
  begin
    #100000;
    failures++;
    complete_run();
  end

  initial
  begin
    {srst, rd, wr, adr, wd, failures, cmp_count, wake_n} = '0;
    srst = 1'b1;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    rchk(CB, 32'h0, "usart_control_b reset");
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h0, "unmapped");
    bus(1'b1, CB, TX);
    rchk(CB, TX, "transmit_enable_bit while off");
    bus(1'b1, CA, 32'h2);
    rchk(CB, 32'h0, "transmit_enable_bit starting");
    repeat (8) @(posedge clk_sys);
    rchk(SY, 32'h0, "sync after start");
    rchk(CB, TX, "transmit_enable_bit running");
    bus(1'b1, CB, 32'h0);
    bus(1'b1, CB, TX);
    rchk(SY, 32'h4, "sync on transmit_enable_bit");
    rchk(CB, TX, "transmit_enable_bit set while on");
    $display("test enable done");
    // Parity even, odd, then no parity slot
    for (int i = 0; i < 3; i++)
    begin
      cfg((i < 2) ? 4'h1 : 4'h0, TX | ((i == 1) ? PM : 32'h0));
      bus(1'b1, DT, 32'hA5);
      wait_frame(i + 1);
      cmpv("tx data", 32'hA5, got[7:0]);
      cmpv("tx bit 9", (i < 2) ? (^8'hA5) ^ (i == 1) : 1'b1, got[8]);
    end
    bus(1'b1, DT, 32'h3C);
    repeat (4) @(posedge clk_sys);
    bus(1'b1, DT, 32'hC3);
    bus(1'b1, CB, 32'h0);
    rchk(CB, 32'h0, "transmit_enable_bit cleared");
    wait_frame(4);
    cmpv("active byte", 32'h3C, got[7:0]);
    wait_frame(5);
    cmpv("held byte", 32'hC3, got[7:0]);
    $display("test transmit done");
    bus(1'b1, CA, 32'h0);
    bus(1'b1, CB, RX);
    rchk(CB, RX, "rxen pending");
    cfg(1, RX);
    bus(1'b1, MK, 32'h8);
    bus(1'b0, ST, 32'h0);
    u_ust_peer.send(8'h5A, 1'b0, 1'b1);
    rchk(DT, 32'h5A, "rx data");
    @(negedge clk_sys);
    cmpv("irq good parity", 1'b0, irq);
    u_ust_peer.send(8'h5A, 1'b1, 1'b1);
    @(negedge clk_sys);
    cmpv("irq bad parity", 1'b1, irq);
    bus(1'b0, ST, 32'h0);
    cmpv("parity flag", 1'b1, q[3]);
    @(negedge clk_sys);
    cmpv("irq cleared", 1'b0, irq);
    $display("test receive done");
    // Receive-complete enable set before wake enable
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, MK, 32'h2);
      cfg(0, RX | ((i == 0) ? SF : 32'h0));
      wake_n = 0;
      u_ust_peer.send(8'h81, 1'b0, 1'b0);
      repeat (4) @(posedge clk_sys);
      cmpv("wake pulses", i == 0, wake_n);
    end
    $display("test wake done");
    cfg(0, TX | EN);
    @(negedge clk_sys);
    cmpv("irda idle", 1'b0, txd_pin);
    bus(1'b1, DT, 32'h00);
    n = 0;
    while (txd_pin !== 1'b1 && n < 100)
      @(negedge clk_sys) n++;
    n = 0;
    while (txd_pin === 1'b1 && n < 20)
      @(negedge clk_sys) n++;
    cmpv("irda pulse", 3, n);
    $display("test irda done");
    complete_run();
  end
endmodule // ust_ctrl_bench

`default_nettype wire
